// file: shared/timer_consts.vh
// Purpose: Constants for the 16-bit timer with prescaler
// Assumes: Byte offsets on a 32-bit AXI4-Lite register bus
// Notes: Definitions only
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register byte offsets
`define OFS_CONTROL 4'h0
`define OFS_COUNT_LOW 4'h4
`define OFS_COUNT_HIGH 4'h8
`define OFS_INT_CTRL 4'hC

// Control field positions
`define CTL_RUN_BIT 0
`define CTL_SRC_BIT 1
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_WRITE_MASK 8'h33

// Interrupt control field positions
`define INT_FLAG_BIT 0
`define INT_OVF_EN_BIT 1
`define INT_PERIPH_EN_BIT 2
`define INT_GLOBAL_EN_BIT 3

// Reset values
`define CONTROL_RESET 8'h00
`define COUNT_RESET 16'h0000

// Instruction clock is the system clock divided by four
`define INSTR_DIV_BITS 2

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: src/timer16.v
// Purpose: 16-bit up-counter with clock source select and prescaler up to 1:8, AXI4-Lite registers
// Assumes: SYS_CLK is the system oscillator clock; inputs synchronous to it
// Notes: Interrupt request is a gated level for the processor core
//   Register map, one 32-bit word each, data in the low byte:
//     0x0 control: run bit 0, source bit 1, prescale bits 5-4
//     0x4 count low byte, live value
//     0x8 count high byte, live value
//     0xC interrupt control: flag bit 0, enables bits 3-1
//   Flag bit 0 clears on a write of zero, a one is ignored
//   Hardware set of the flag beats a clear in the same cycle
//   Unmapped addresses answer SLVERR and read as zero
//   Byte lanes other than lane 0 are ignored
//   Write strobe lane 0 low makes the write a no-op
//   Write response one cycle after both channels are taken
//   Read data one cycle after the address is taken
//   One write and one read may be under way together
//   Readies pulse for one cycle, then wait for the answer
//   Instruction clock is SYS_CLK divided by four
//   The divider runs free, so a start may see up to
//   three cycles of phase error in the first count
//   Gate flip-flop lags the run bit by one cycle
//   Sleep freezes the divider, prescaler and count
//   Sleep also forces the request low, so no wake
//   No latch between bytes: software reading low then
//   high may see a carry land between the two reads
//   Prescaler width is a parameter; three bits cover 1:8
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "timer_consts.vh"

module timer16 #(
    parameter PRESCALE_BITS = 3
) (
    input wire SYS_CLK, // System clock
    input wire RST, // Synchronous reset, active high
    input wire SLEEP, // Processor in sleep
    input wire [3:0] S_AXI_AWADDR, // Write address
    input wire S_AXI_AWVALID, // Write address valid
    output reg S_AXI_AWREADY, // Write address ready
    input wire [31:0] S_AXI_WDATA, // Write data
    input wire [3:0] S_AXI_WSTRB, // Write strobes
    input wire S_AXI_WVALID, // Write data valid
    output reg S_AXI_WREADY, // Write data ready
    output reg [1:0] S_AXI_BRESP, // Write response
    output reg S_AXI_BVALID, // Write response valid
    input wire S_AXI_BREADY, // Write response ready
    input wire [3:0] S_AXI_ARADDR, // Read address
    input wire S_AXI_ARVALID, // Read address valid
    output reg S_AXI_ARREADY, // Read address ready
    output reg [31:0] S_AXI_RDATA, // Read data
    output reg [1:0] S_AXI_RRESP, // Read response
    output reg S_AXI_RVALID, // Read data valid
    input wire S_AXI_RREADY, // Read data ready
    output reg OVERFLOW_IRQ // Gated overflow interrupt request
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    // Count, prescaler, divider, gate and flag are the timing state;
    // the bus side only holds what it needs to pair the
    // write address with its data
    reg [7:0] control_reg;
    reg [15:0] count_reg;
    reg [15:0] count_next;
    reg [PRESCALE_BITS-1:0] prescale_reg;
    reg [PRESCALE_BITS-1:0] prescale_next;
    reg [`INSTR_DIV_BITS-1:0] instr_div_reg;
    reg gate_reg;
    reg overflow_flag_reg;
    reg overflow_flag_next;
    reg ovf_en_reg;
    reg periph_en_reg;
    reg global_en_reg;
    reg [3:0] aw_addr_reg;
    reg aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_held_reg;

    wire run_enable_bit = control_reg[`CTL_RUN_BIT];
    wire clock_source_select = control_reg[`CTL_SRC_BIT];
    wire [1:0] prescale_select = control_reg[`CTL_PS_HI:`CTL_PS_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Write channel capture, either order
    // An item taken this cycle is used directly, an item
    // taken earlier comes from its holding register; this
    // lets the write land on the edge of the second take
    // without waiting one more cycle
    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire [3:0] wr_addr = aw_take ? S_AXI_AWADDR : aw_addr_reg;
    wire [31:0] wr_data = w_take ? S_AXI_WDATA : w_data_reg;
    wire [3:0] wr_strb = w_take ? S_AXI_WSTRB : w_strb_reg;
    wire wr_fire = (aw_take || aw_held_reg) && (w_take || w_held_reg) && !S_AXI_BVALID;
    wire wr_lane0 = wr_fire && wr_strb[0];
    wire wr_ctrl = wr_lane0 && (wr_addr == `OFS_CONTROL);
    wire wr_low = wr_lane0 && (wr_addr == `OFS_COUNT_LOW);
    wire wr_high = wr_lane0 && (wr_addr == `OFS_COUNT_HIGH);
    wire wr_int = wr_lane0 && (wr_addr == `OFS_INT_CTRL);
    wire wr_mapped = (wr_addr == `OFS_CONTROL) || (wr_addr == `OFS_COUNT_LOW) ||
                     (wr_addr == `OFS_COUNT_HIGH) || (wr_addr == `OFS_INT_CTRL);

    // Channel handshakes; each ready drops once its item is held
    // Readies are registered, so they rise one cycle after idle
    // and fall again the next cycle; a master must hold valid
    // until it sees its own ready high at an edge
    // The response stays up until the master takes it
    always @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_reg <= 1'b1;
                end
                if (w_take) begin
                    w_held_reg <= 1'b1;
                end
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
            // Ready only while idle so one write is under way at a time
            S_AXI_AWREADY <= !S_AXI_AWREADY && !aw_held_reg && !aw_take && !wr_fire && !S_AXI_BVALID;
            S_AXI_WREADY <= !S_AXI_WREADY && !w_held_reg && !w_take && !wr_fire && !S_AXI_BVALID;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and interrupt enable registers
    // Unused control bits are masked on the way in, so they
    // can never hold a one and always read back as zero
    // The flag bit is handled with the counter below
    always @(posedge SYS_CLK) begin
        if (RST) begin
            control_reg <= `CONTROL_RESET;
            ovf_en_reg <= 1'b0;
            periph_en_reg <= 1'b0;
            global_en_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                control_reg <= wr_data[7:0] & `CTL_WRITE_MASK;
            end
            if (wr_int) begin
                ovf_en_reg <= wr_data[`INT_OVF_EN_BIT];
                periph_en_reg <= wr_data[`INT_PERIPH_EN_BIT];
                global_en_reg <= wr_data[`INT_GLOBAL_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock source and prescaler tick generation
    // The divider by four stands in for the instruction clock
    // It keeps running while the timer is stopped, trading a
    // small start-up phase error for a steady instruction rate
    // Instruction clock runs free so its phase does not depend on the run bit
    always @(posedge SYS_CLK) begin
        if (RST) begin
            instr_div_reg <= {`INSTR_DIV_BITS{1'b0}};
        end else if (!SLEEP) begin
            instr_div_reg <= instr_div_reg + 1'b1;
        end
    end

    wire src_tick = clock_source_select ? 1'b1 : (instr_div_reg == {`INSTR_DIV_BITS{1'b1}});
    wire active = gate_reg && run_enable_bit && !SLEEP;
    wire [PRESCALE_BITS-1:0] ps_limit = ({{(PRESCALE_BITS-1){1'b0}}, 1'b1} << prescale_select) - 1'b1;
    wire count_tick = active && src_tick && (prescale_reg == ps_limit);

    // Prescale limit is one less than the division ratio
    // A tick only moves the count when the prescaler wraps
    // Sleep and the gate both block the tick
    //
    // Gate follows the run bit; clearing the run bit clears it
    // No separate gate input, so a plain delayed copy suffices
    always @(posedge SYS_CLK) begin
        if (RST) begin
            gate_reg <= 1'b0;
        end else begin
            gate_reg <= run_enable_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter next state
    // While halted nothing changes, so the live count reads back
    // A byte write clears the prescaler, so the next increment
    // comes a full prescale period after the write
    // The other byte still takes an increment that lands in the same cycle
    always @* begin
        prescale_next = prescale_reg;
        count_next = count_reg;
        if (active && src_tick) begin
            prescale_next = (prescale_reg == ps_limit) ? {PRESCALE_BITS{1'b0}} : prescale_reg + 1'b1;
        end
        if (count_tick) begin
            count_next = count_reg + 16'h0001;
        end
        // Byte writes win over an increment in the same cycle
        if (wr_low) begin
            count_next[7:0] = wr_data[7:0];
            prescale_next = {PRESCALE_BITS{1'b0}};
        end
        if (wr_high) begin
            count_next[15:8] = wr_data[7:0];
            prescale_next = {PRESCALE_BITS{1'b0}};
        end
    end

    // Overflow flag: the wrap wins over a software clear
    // Losing a wrap would hide an overflow from software, while
    // a late clear only costs one extra pass of the handler
    always @* begin
        overflow_flag_next = overflow_flag_reg;
        if (wr_int && !wr_data[`INT_FLAG_BIT]) begin
            overflow_flag_next = 1'b0;
        end
        if (count_tick && (count_reg == 16'hFFFF)) begin
            overflow_flag_next = 1'b1;
        end
    end

    always @(posedge SYS_CLK) begin
        if (RST) begin
            count_reg <= `COUNT_RESET;
            prescale_reg <= {PRESCALE_BITS{1'b0}};
            overflow_flag_reg <= 1'b0;
            OVERFLOW_IRQ <= 1'b0;
        end else begin
            // Registered request keeps the output glitch free,
            // at the price of one cycle of extra latency
            count_reg <= count_next;
            prescale_reg <= prescale_next;
            overflow_flag_reg <= overflow_flag_next;
            // Request held off in sleep so it cannot wake the core
            OVERFLOW_IRQ <= overflow_flag_reg && run_enable_bit && ovf_en_reg &&
                            periph_en_reg && global_en_reg && !SLEEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data
    // Decode is on the raw address so the data can be latched
    // on the edge that takes it; unmapped words read as zero
    // and answer with an error response
    reg [31:0] rd_value;
    reg rd_ok;
    always @* begin
        rd_value = 32'h0;
        rd_ok = 1'b1;
        if (S_AXI_ARADDR == `OFS_CONTROL) begin
            rd_value[7:0] = control_reg & `CTL_WRITE_MASK;
        end else if (S_AXI_ARADDR == `OFS_COUNT_LOW) begin
            rd_value[7:0] = count_reg[7:0];
        end else if (S_AXI_ARADDR == `OFS_COUNT_HIGH) begin
            rd_value[7:0] = count_reg[15:8];
        end else if (S_AXI_ARADDR == `OFS_INT_CTRL) begin
            rd_value[3:0] = {global_en_reg, periph_en_reg, ovf_en_reg, overflow_flag_reg};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            // Data and response are frozen until the master takes them
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_value;
                S_AXI_RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (S_AXI_RVALID && S_AXI_RREADY) begin
                    S_AXI_RVALID <= 1'b0;
                end
                S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            end
        end
    end

endmodule

// file: verif/timer16_monitor.sv
// Purpose: Read channel and interrupt checks for timer16
// Assumes: One clock domain, synchronous reset
// Notes: Bound to the design at the foot
`timescale 1ns/10ps
module timer16_monitor (
    input wire SYS_CLK, // Clock
    input wire RST, // Reset
    input wire SLEEP, // Sleep
    input wire [3:0] S_AXI_ARADDR, // Read address
    input wire S_AXI_ARVALID, // Address valid
    input wire S_AXI_ARREADY, // Address ready
    input wire [31:0] S_AXI_RDATA, // Read data
    input wire [1:0] S_AXI_RRESP, // Read response
    input wire S_AXI_RVALID, // Data valid
    input wire S_AXI_RREADY, // Data ready
    input wire S_AXI_BVALID, // Write response valid
    input wire OVERFLOW_IRQ // Request
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    reg [3:0] ra; // Address of the read under way
    // Remember the taken read address
    always @(posedge SYS_CLK) begin
        if (S_AXI_ARVALID && S_AXI_ARREADY) ra <= S_AXI_ARADDR;
    end
    ////////////////////////////////////////////////////////////
    // Request falls only after a register write or sleep, never by itself
    chk_sleep_irq: assert property (SLEEP |=> !OVERFLOW_IRQ) else $error("request in sleep");
    chk_irq_awake: assert property (OVERFLOW_IRQ |-> !$past(SLEEP)) else $error("request after sleep");
    chk_irq_sticky: assert property ($fell(OVERFLOW_IRQ) |-> $past(SLEEP) || $past(S_AXI_BVALID)
        || $past(S_AXI_BVALID, 2)) else $error("request dropped alone");
    chk_rd_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000) else $error("upper bits");
    chk_ctl_unused: assert property (S_AXI_RVALID && ra == 4'h0 |-> (S_AXI_RDATA & 32'hFFFFFFCC) == 32'h0)
        else $error("unused control bits");
    chk_rd_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data moved");
    chk_rd_okay: assert property (S_AXI_RVALID && ra[1:0] == 2'h0 |-> S_AXI_RRESP == 2'h0)
        else $error("mapped read refused");
    chk_ar_pulse: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY) else $error("address ready held");
endmodule
////////////////////////////////////////////////////////////
bind timer16 timer16_monitor timer16_monitor_i (.SYS_CLK(SYS_CLK), .RST(RST), .SLEEP(SLEEP),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BVALID(S_AXI_BVALID), .OVERFLOW_IRQ(OVERFLOW_IRQ));

// file: verif/timer16_tb.sv
// Purpose: Self-checking bench for timer16
// Assumes: Bench is the AXI4-Lite master
// Notes: Reads are scored from a queue
`timescale 1ns/10ps
module timer16_tb;
    reg clk = 1'h0, rst = 1'h1, slp = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    reg [3:0] awa = 4'h0, ara = 4'h0;
    reg [1:0] eb = 2'h0;
    reg [31:0] wd = 32'h0, lf = 32'h7762D07C;
    wire awr, wr_rdy, bv, arr, rv, irq;
    wire [1:0] br, rr;
    wire [31:0] rd_d;
    integer error_cnt = 0, compares = 0, cyc = 0, t0, tw, n, i, k;
    reg [33:0] eq [$];
    reg [7:0] tq [$];
    timer16 #(.PRESCALE_BITS(3)) timer16_i (.SYS_CLK(clk), .RST(rst), .SLEEP(slp), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rry), .OVERFLOW_IRQ(irq));
    ////////////////////////////////////////////////////////////
    // Clock and cycle count
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function [31:0] nx(input [31:0] x);
        nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task final_report;
        begin
            $display("Compares %0d, mismatches %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // Tolerance allows for the free-running divider phase
    task chk(input string nm, input [33:0] e, input [33:0] s, input [7:0] t);
        begin
            compares = compares + 1;
            if ((s[33:32] === e[33:32] && s[31:0] + t >= e[31:0] && s[31:0] <= e[31:0] + t) !== 1'h1) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // Hold each channel until its own ready, then wait for the answer
    task go;
        begin
            k = 0;
            while (k < 8'h40) begin
                @(posedge clk);
                k = k + 1;
                if (awr === 1'h1) awv <= 1'h0;
                if (wr_rdy === 1'h1) wv <= 1'h0;
                if (arr === 1'h1) arv <= 1'h0;
                if ((bv & bry) === 1'h1) chk("bresp", {eb, 32'h0}, {br, 32'h0}, 8'h0);
                if ((bv & bry) === 1'h1 || (rv & rry) === 1'h1) k = 8'hFF;
            end
            tw = cyc;
            bry <= 1'h0;
            rry <= 1'h0;
            if (k != 8'hFF) begin
                error_cnt = error_cnt + 1;
                final_report;
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            lf = nx(lf);
            eb = (a[1:0] == 2'h0) ? 2'h0 : 2'h2;
            awa <= a;
            wd <= {lf[31:8], d};
            awv <= 1'h1;
            wv <= 1'h1;
            bry <= 1'h1;
            go;
        end
    endtask
    task rd(input [3:0] a, input [33:0] e, input [7:0] t);
        begin
            @(posedge clk);
            eq.push_back(e);
            tq.push_back(t);
            ara <= a;
            arv <= 1'h1;
            rry <= 1'h1;
            go;
        end
    endtask
    // Score each read as it is handed over
    always @(posedge clk) begin
        if (rv === 1'h1 && rry === 1'h1) chk("rdata", eq.pop_front(), {rr, rd_d}, tq.pop_front());
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8'hC) @(posedge clk);
        rst <= 1'h0;
        for (i = 0; i < 4; i = i + 1) rd({i[1:0], 2'h0}, 34'h0, 8'h0);
        rd(4'h6, 34'h200000000, 8'h0);
        wr(4'h6, 8'h55);
        wr(4'h0, 8'hFF);
        rd(4'h0, 34'h33, 8'h0);
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h5A);
        wr(4'h8, 8'hA5);
        rd(4'h8, 34'hA5, 8'h0);
        rd(4'h4, 34'h5A, 8'h0);
        // Run for a random span under each source and prescale
        for (i = 0; i < 8; i = i + 1) begin
            wr(4'h4, 8'h00);
            wr(4'h8, 8'h00);
            wr(4'h0, {2'h0, i[1:0], 2'h0, i[2], 1'h1});
            t0 = tw;
            repeat (8'h60 + lf[5:0]) @(posedge clk);
            wr(4'h0, {2'h0, i[1:0], 2'h0, i[2], 1'h0});
            n = (tw - t0) / ((i[2] ? 8'h1 : 8'h4) << i[1:0]);
            rd(4'h4, {2'h0, n[31:0]}, 8'h2);
            rd(4'h8, 34'h0, 8'h0);
        end
        // Sleep freezes a running count
        slp <= 1'h1;
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h03);
        repeat (8'h28) @(posedge clk);
        rd(4'h4, 34'h0, 8'h0);
        slp <= 1'h0;
        // Roll over with all enables, then mask, sleep and clear
        wr(4'h0, 8'h00);
        wr(4'h8, 8'h00);
        wr(4'h4, 8'h00);
        wr(4'hC, 8'h0E);
        wr(4'h8, 8'hFF);
        wr(4'h4, 8'hF0);
        wr(4'h0, 8'h03);
        for (k = 0; k < 8'h64 && irq !== 1'h1; k = k + 1) @(posedge clk);
        chk("irq", 34'h1, {33'h0, irq}, 8'h0);
        rd(4'hC, 34'hF, 8'h0);
        wr(4'hC, 8'h07);
        repeat (3) @(posedge clk);
        chk("irq", 34'h0, {33'h0, irq}, 8'h0);
        wr(4'hC, 8'h0F);
        repeat (3) @(posedge clk);
        chk("irq", 34'h1, {33'h0, irq}, 8'h0);
        slp <= 1'h1;
        repeat (3) @(posedge clk);
        chk("irq", 34'h0, {33'h0, irq}, 8'h0);
        slp <= 1'h0;
        wr(4'hC, 8'h0E);
        rd(4'hC, 34'hE, 8'h0);
        final_report;
    end
endmodule
